// file: shared/stp_pkg.sv
package stp_pkg;
  // Notes on behaviour
  // - In indexer mode each rising step edge advances the position by one step.
  // - The direction input reverses the order the indexer walks its sequence.
  // - Two step size selects choose full, half, quarter or 1/32 step.
  // - Phase/enable mode with select 1 high: gate low turns the winding off.
  // - Sense above the 0.5 V trip level flags overcurrent on that bridge.
  // - After reaching the chop threshold, decay holds until the PWM period ends.
  // - Each winding decays slow, fast or mixed during the chopping off time.
  // - The chop comparison is ignored during blanking at each drive phase start.
  // - Full-scale threshold equals current reference divided by a sense gain of five.
  // - Sleep request disables bridges, resets all logic, homes indexer, ignores inputs.
  // - Leaving sleep, fault output stays low for up to 1 ms.

  ////////////////////////////////////////////////////////////////////////////
  // Clock and timing
  localparam int CLK_HZ = 50_000_000;
  localparam int WAKE_TIME_MS = 1;
  // Longest time, so the count rounds down
  localparam int WAKE_CYC = WAKE_TIME_MS * (CLK_HZ / 1000);
  localparam logic [15:0] MIX_FAST_CYC = 16'h0064;
  localparam logic [7:0] SENSE_GAIN = 8'h05;

  ////////////////////////////////////////////////////////////////////////////
  // Indexer: 128 positions per electrical cycle, home at 45 degrees
  localparam logic [6:0] HOME_POS = 7'h10;
  localparam logic [6:0] INC_FULL = 7'h20;
  localparam logic [6:0] INC_HALF = 7'h10;
  localparam logic [6:0] INC_QTR = 7'h08;
  localparam logic [6:0] INC_FINE = 7'h01;

  ////////////////////////////////////////////////////////////////////////////
  // Register map (byte offsets) and word indices
  localparam logic [31:0] OFS_CTRL = 32'h0000_0000;
  localparam logic [31:0] OFS_CUR_REF = 32'h0000_0004;
  localparam logic [31:0] OFS_TIMING = 32'h0000_0008;
  localparam logic [31:0] OFS_STATUS = 32'h0000_000C;
  localparam logic [31:0] OFS_FULL_SCALE = 32'h0000_0010;
  localparam logic [2:0] IDX_CTRL = 3'h0;
  localparam logic [2:0] IDX_CUR_REF = 3'h1;
  localparam logic [2:0] IDX_TIMING = 3'h2;
  localparam logic [2:0] IDX_STATUS = 3'h3;
  localparam logic [2:0] IDX_FULL_SCALE = 3'h4;
  localparam logic [2:0] IDX_NONE = 3'h7;

  // Control field positions
  localparam int CTRL_MODE_PE = 0;
  localparam int CTRL_SEL0 = 1;
  localparam int CTRL_SEL1 = 2;
  localparam int CTRL_DEC_A = 4;
  localparam int CTRL_DEC_B = 6;
  // Status field positions
  localparam int STAT_OVC = 8;
  localparam int STAT_WAKING = 10;
  localparam int STAT_DECAY = 11;

  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [15:0] CUR_REF_RST = 16'h8080;
  localparam logic [15:0] PERIOD_RST = 16'h03E8;
  localparam logic [7:0] BLANK_RST = 8'h32;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {DEC_SLOW, DEC_FAST, DEC_MIXED, DEC_SPARE} stp_decay_t;
  typedef enum logic [1:0] {BR_OFF, BR_DRIVE, BR_SLOW, BR_FAST} stp_br_mode_t;
  typedef struct packed {
    stp_br_mode_t mode;
    logic fwd;
  } stp_bridge_t;
  typedef struct packed {
    logic at_chop;
    logic over_trip;
  } stp_sense_t;
endpackage : stp_pkg

// file: logic/stp_chopper.sv
module stp_chopper
  import stp_pkg::*;
#(
  parameter int CNT_W = 16,
  parameter int BLANK_W = 8
)(
  input wire logic core_clk, // System clock
  input wire logic run_rst_n, // Reset or sleep, active low
  input wire logic run, // Winding allowed to drive
  input wire logic at_chop, // Current at chop threshold
  input wire logic [CNT_W-1:0] period, // PWM period in cycles
  input wire logic [BLANK_W-1:0] blank_interval, // Blanking in cycles
  input wire stp_decay_t decay_sel, // Decay style
  output stp_br_mode_t mode, // Drive or decay, registered
  output logic decaying // Off part of the period
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] fcnt;
    logic decaying;
    stp_br_mode_t mode;
  } stp_chop_state_t;

  stp_chop_state_t q;
  stp_chop_state_t d;

  ////////////////////////////////////////////////////////////////////////////
  // Fixed-frequency chopping; counter restarts each period
  always_comb
  begin
    d = q;
    if (!run_rst_n || !run)
    begin
      d.cnt = '0;
      d.fcnt = '0;
      d.decaying = 1'b0;
    end
    else if ({1'b0, q.cnt} + 1'b1 >= {1'b0, period})
    begin
      d.cnt = '0;
      d.fcnt = '0;
      d.decaying = 1'b0;
    end
    else
    begin
      d.cnt = q.cnt + 1'b1;
      // Overshoot in the blanking window is accepted to reject switching spikes
      if (!q.decaying && q.cnt >= CNT_W'(blank_interval) && at_chop)
        d.decaying = 1'b1;
      if (q.decaying && q.fcnt != '1)
        d.fcnt = q.fcnt + 1'b1;
    end
    // Mixed decay is fast first, then slow for the rest of the period
    if (!d.decaying)
      d.mode = BR_DRIVE;
    else
      case (decay_sel)
        DEC_FAST: d.mode = BR_FAST;
        DEC_MIXED: d.mode = (d.fcnt < CNT_W'(MIX_FAST_CYC)) ? BR_FAST : BR_SLOW;
        default: d.mode = BR_SLOW;
      endcase
  end

  always_ff @(posedge core_clk)
    q <= d;

  assign mode = q.mode;
  assign decaying = q.decaying;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_blank_no_decay: assert property (@(posedge core_clk) disable iff (!run_rst_n)
    run && !q.decaying && q.cnt + 1'b1 < CNT_W'(blank_interval) && q.cnt + 1'b1 < period |=> !q.decaying)
    else $error("Decay began inside the blanking interval");
  a_decay_holds: assert property (@(posedge core_clk) disable iff (!run_rst_n)
    run && q.decaying && {1'b0, q.cnt} + 1'b1 < {1'b0, period} ##1 run |-> q.decaying && q.mode != BR_DRIVE)
    else $error("Decay ended before the PWM period");
  c_decay_start: cover property (@(posedge core_clk) disable iff (!run_rst_n) $rose(q.decaying));
endmodule : stp_chopper

// file: logic/stp_core.sv
// Design decisions made here: the placing of the registers and register access over AHB-Lite.
module stp_core
  import stp_pkg::*;
#(
  parameter int WAKE_CYC_P = WAKE_CYC
)(
  input wire logic core_clk, // System clock, 50 MHz
  input wire logic reset_n, // Synchronous reset, active low
  input wire logic hsel, // AHB-Lite select
  input wire logic [31:0] haddr, // AHB-Lite address
  input wire logic [1:0] htrans, // AHB-Lite transfer type
  input wire logic hwrite, // AHB-Lite write
  input wire logic [2:0] hsize, // AHB-Lite size
  input wire logic [31:0] hwdata, // AHB-Lite write data
  input wire logic hready, // AHB-Lite bus ready
  output logic hreadyout, // AHB-Lite slave ready
  output logic [31:0] hrdata, // AHB-Lite read data
  output logic hresp, // AHB-Lite response, always OKAY
  input wire logic low_power_request_n, // Sleep request, active low
  input wire logic step_pulse, // Indexer step input
  input wire logic rotation_dir, // Indexer direction
  input wire logic [1:0] phase_in, // Phase/enable polarity, bit 0 is A
  input wire logic [1:0] bridge_drive_gate, // Phase/enable gate, bit 0 is A
  input wire stp_sense_t [1:0] sense, // Comparator results per winding
  output stp_bridge_t [1:0] bridge_out, // Bridge command per winding
  output logic [1:0][7:0] chop_threshold, // Full-scale threshold codes
  output logic [6:0] step_position, // Indexer position
  output logic fault_out_n // Fault, active low
);
  localparam int WK_W = $clog2(WAKE_CYC_P + 1);

  typedef struct packed {
    logic [1:0] step_sync;
    logic [1:0] dir_sync;
    logic step_prev;
    logic [6:0] pos;
    logic [WK_W-1:0] wake_cnt;
    logic waking;
    logic [1:0] ovc;
    logic fault_n;
    stp_bridge_t [1:0] br;
    logic [1:0][7:0] fs;
    logic [7:0] ctrl;
    logic [15:0] cur_ref;
    logic [15:0] period;
    logic [7:0] blank;
    logic ap_wr;
    logic rd_pend;
    logic [2:0] ap_idx;
    logic [31:0] rdata;
  } stp_core_state_t;

  stp_core_state_t q;
  stp_core_state_t d;
  logic sys_ok;
  logic mode_pe;
  logic hit;
  logic step_edge;
  logic [6:0] step_inc;
  logic [2:0] idx;
  logic [1:0] run;
  logic [1:0] pol;
  logic [1:0] decaying;
  stp_br_mode_t [1:0] chop_mode;
  stp_decay_t [1:0] decay_sel;

  ////////////////////////////////////////////////////////////////////////////
  // Sleep acts as a second reset source for the whole block
  assign sys_ok = reset_n && low_power_request_n;
  assign mode_pe = q.ctrl[CTRL_MODE_PE];
  assign decay_sel[0] = stp_decay_t'(q.ctrl[CTRL_DEC_A +: 2]);
  assign decay_sel[1] = stp_decay_t'(q.ctrl[CTRL_DEC_B +: 2]);

  // Edge taken from the second and third stage only
  assign step_edge = q.step_sync[1] && !q.step_prev;

  // Step size selects map to position increments
  always_comb
  begin
    case ({q.ctrl[CTRL_SEL1], q.ctrl[CTRL_SEL0]})
      2'b00: step_inc = INC_FULL;
      2'b01: step_inc = INC_HALF;
      2'b10: step_inc = INC_QTR;
      default: step_inc = INC_FINE;
    endcase
  end

  // Winding polarity follows the cosine and sine quadrants of the position
  assign pol[0] = (q.pos[6:5] == 2'b00) || (q.pos[6:5] == 2'b11);
  assign pol[1] = !q.pos[6];

  // Chopper runs only when awake, free of overcurrent and, in phase/enable mode, gated on
  always_comb
  begin
    for (int w = 0; w < 2; w++)
      run[w] = !q.waking && !q.ovc[w] && (!mode_pe || bridge_drive_gate[w]);
  end

  ////////////////////////////////////////////////////////////////////////////
  // One chopper per winding
  for (genvar w = 0; w < 2; w++)
  begin : g_chop
    stp_chopper #(
      .CNT_W(16),
      .BLANK_W(8)
    ) u_chop (
      .core_clk(core_clk),
      .run_rst_n(sys_ok),
      .run(run[w]),
      .at_chop(sense[w].at_chop),
      .period(q.period),
      .blank_interval(q.blank),
      .decay_sel(decay_sel[w]),
      .mode(chop_mode[w]),
      .decaying(decaying[w])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite decode: word transfers inside the map only
  assign hit = hsel && htrans[1] && hready;

  always_comb
  begin
    if (haddr[31:5] != '0 || haddr[1:0] != 2'b00 || hsize != 3'b010)
      idx = IDX_NONE;
    else
      case (haddr)
        OFS_CTRL: idx = IDX_CTRL;
        OFS_CUR_REF: idx = IDX_CUR_REF;
        OFS_TIMING: idx = IDX_TIMING;
        OFS_STATUS: idx = IDX_STATUS;
        OFS_FULL_SCALE: idx = IDX_FULL_SCALE;
        default: idx = IDX_NONE;
      endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state of the whole block
  always_comb
  begin
    d = q;
    // Bus address phase; reads take one wait state so a write just done is seen
    d.ap_wr = hit && hwrite;
    d.rd_pend = hit && !hwrite;
    if (hit)
      d.ap_idx = idx;
    if (q.rd_pend)
      case (q.ap_idx)
        IDX_CTRL: d.rdata = {24'h00_0000, q.ctrl};
        IDX_CUR_REF: d.rdata = {16'h0000, q.cur_ref};
        IDX_TIMING: d.rdata = {8'h00, q.blank, q.period};
        IDX_STATUS: d.rdata = {19'h0_0000, decaying, q.waking, q.ovc, 1'b0, q.pos};
        IDX_FULL_SCALE: d.rdata = {16'h0000, q.fs[1], q.fs[0]};
        default: d.rdata = 32'h0000_0000;
      endcase
    // Bus write data phase
    if (q.ap_wr)
      case (q.ap_idx)
        IDX_CTRL: d.ctrl = hwdata[7:0];
        IDX_CUR_REF: d.cur_ref = hwdata[15:0];
        IDX_TIMING:
        begin
          d.period = hwdata[15:0];
          d.blank = hwdata[23:16];
        end
        IDX_STATUS: d.ovc = q.ovc & ~hwdata[STAT_OVC +: 2];
        default: d.ctrl = q.ctrl;
      endcase

    // Two-flop synchronisers for step and direction
    d.step_sync = {q.step_sync[0], step_pulse};
    d.dir_sync = {q.dir_sync[0], rotation_dir};
    d.step_prev = q.step_sync[1];

    // Supply settling after sleep or reset
    if (q.waking)
    begin
      d.wake_cnt = q.wake_cnt + 1'b1;
      if (q.wake_cnt == WK_W'(WAKE_CYC_P - 1))
        d.waking = 1'b0;
    end

    // Indexer; 7-bit arithmetic wraps over the 128-position cycle
    if (!q.waking && !mode_pe && step_edge)
    begin
      if (q.dir_sync[1])
        d.pos = q.pos + step_inc;
      else
        d.pos = q.pos - step_inc;
    end

    // Overcurrent set after the clear so a same-cycle trip wins
    for (int w = 0; w < 2; w++)
      if (!q.waking && sense[w].over_trip)
        d.ovc[w] = 1'b1;

    // Bridge commands; latched overcurrent forces the bridge off
    for (int w = 0; w < 2; w++)
    begin
      d.br[w].fwd = mode_pe ? phase_in[w] : pol[w];
      if (q.waking || d.ovc[w])
        d.br[w].mode = BR_OFF;
      else if (mode_pe && !bridge_drive_gate[w])
        d.br[w].mode = q.ctrl[CTRL_SEL1] ? BR_OFF : BR_SLOW;
      else
        d.br[w].mode = chop_mode[w];
    end

    // Threshold at the largest microstep current
    d.fs[0] = q.cur_ref[7:0] / SENSE_GAIN;
    d.fs[1] = q.cur_ref[15:8] / SENSE_GAIN;

    d.fault_n = !(d.waking || (|d.ovc));

    // Reset and sleep override everything, homing the indexer
    if (!sys_ok)
    begin
      d = '0;
      d.pos = HOME_POS;
      d.waking = 1'b1;
      d.ctrl = CTRL_RST;
      d.cur_ref = CUR_REF_RST;
      d.period = PERIOD_RST;
      d.blank = BLANK_RST;
      d.ap_idx = IDX_NONE;
    end
  end

  always_ff @(posedge core_clk)
    q <= d;

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign hreadyout = !q.rd_pend;
  assign hrdata = q.rdata;
  assign hresp = 1'b0;
  assign bridge_out = q.br;
  assign chop_threshold = q.fs;
  assign step_position = q.pos;
  assign fault_out_n = q.fault_n;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!sys_ok);

  a_step_advance: assert property (
    !q.waking && !mode_pe && q.step_sync[1] && !q.step_prev |=>
      q.pos == ($past(q.dir_sync[1]) ? $past(q.pos) + $past(step_inc) : $past(q.pos) - $past(step_inc)))
    else $error("Step edge did not move the position by the selected increment");
  a_step_once: assert property (
    !q.step_sync[1] ##1 q.step_sync[1] [*3] |-> q.pos == $past(q.pos))
    else $error("A held step level moved the position again");
  a_sleep_home: assert property (@(posedge core_clk) disable iff (!reset_n)
    !low_power_request_n |=> q.pos == HOME_POS && bridge_out[0].mode == BR_OFF && bridge_out[1].mode == BR_OFF)
    else $error("Sleep did not home the indexer and turn the bridges off");
  a_wake_fault: assert property (@(posedge core_clk) disable iff (!reset_n)
    $rose(low_power_request_n) |-> !fault_out_n [*8])
    else $error("Fault output rose too early after sleep");
  a_wake_end: assert property (
    q.waking && q.wake_cnt == WK_W'(WAKE_CYC_P - 1) && !sense[0].over_trip && !sense[1].over_trip
      && q.ovc == 2'b00 && !(q.ap_wr) |=> fault_out_n)
    else $error("Fault output stayed low after the wake time");
  a_ovc_trip: assert property (
    !q.waking && sense[0].over_trip |=> q.ovc[0] && !fault_out_n && bridge_out[0].mode == BR_OFF)
    else $error("Sense trip did not flag overcurrent");
  a_pe_off: assert property (
    mode_pe && q.ctrl[CTRL_SEL1] && !bridge_drive_gate[1] ##1 q.ctrl[CTRL_MODE_PE] && q.ctrl[CTRL_SEL1]
      |-> bridge_out[1].mode == BR_OFF)
    else $error("Gate low did not turn the winding off");
  a_fs_gain: assert property (
    sys_ok && $stable(q.cur_ref) |=> {3'b000, chop_threshold[0]} * 11'd5 <= {3'b000, $past(q.cur_ref[7:0])}
      && {3'b000, $past(q.cur_ref[7:0])} < ({3'b000, chop_threshold[0]} + 11'd1) * 11'd5)
    else $error("Full-scale threshold does not follow the reference with gain five");
  a_rd_wait: assert property (
    hit && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("Read did not take exactly one wait state");

  c_pos_wrap: cover property (q.pos == 7'h7F ##1 q.pos == 7'h00);
  c_pe_brake: cover property (mode_pe && bridge_out[0].mode == BR_SLOW);
  c_ovc: cover property ($rose(q.ovc[1]));
endmodule : stp_core

// file: bench/stp_host_model.sv
module stp_host_model (
  output logic step_pulse, // Step square wave
  output logic rotation_dir, // Rotation sense
  input wire logic core_clk // System clock
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle low with a defined direction, so nothing moves before the first request
  initial
  begin
    step_pulse = 1'b0;
    rotation_dir = 1'b1;
  end

  // Steady square wave; each level is held 3 cycles so the synchroniser sees every edge once
  task automatic send_steps(input int n, input logic dir);
    rotation_dir <= dir;
    repeat (3) @(posedge core_clk);
    repeat (n)
    begin
      step_pulse <= 1'b1;
      repeat (3) @(posedge core_clk);
      step_pulse <= 1'b0;
      repeat (3) @(posedge core_clk);
    end
    repeat (3) @(posedge core_clk);
  endtask : send_steps
endmodule : stp_host_model

// file: bench/stp_core_tb.sv
module stp_core_tb;
  import stp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // Short wake time keeps the run brief
  localparam int WAKE = 20;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic hready;
  logic hreadyout;
  logic [31:0] hrdata;
  logic hresp;
  logic low_power_request_n = 1'b1;
  logic step_pulse;
  logic rotation_dir;
  logic [1:0] phase_in = 2'b00;
  logic [1:0] bridge_drive_gate = 2'b00;
  stp_sense_t [1:0] sense = '0;
  stp_bridge_t [1:0] bridge_out;
  logic [1:0][7:0] chop_threshold;
  logic [6:0] step_position;
  logic fault_out_n;
  int num_errors = 0;
  int total_checks = 0;

  ////////////////////////////////////////
  // Clock, and the single slave's ready closes the bus loop
  always #10 core_clk = ~core_clk;
  assign hready = hreadyout;

  stp_core #(.WAKE_CYC_P(WAKE)) u_dut (.core_clk(core_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .low_power_request_n(low_power_request_n), .step_pulse(step_pulse),
    .rotation_dir(rotation_dir), .phase_in(phase_in), .bridge_drive_gate(bridge_drive_gate), .sense(sense),
    .bridge_out(bridge_out), .chop_threshold(chop_threshold), .step_position(step_position),
    .fault_out_n(fault_out_n));
  stp_host_model u_host (.step_pulse(step_pulse), .rotation_dir(rotation_dir), .core_clk(core_clk));

  ////////////////////////////////////////
  // Comparison and verdict
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : close_out

  ////////////////////////////////////////
  // Bus master; no wait count is assumed, the watchdog bounds a hang
  task automatic wait_rdy();
    do @(posedge core_clk); while (hready !== 1'b1);
  endtask : wait_rdy

  task automatic addr_phase(input logic [31:0] a, input logic w);
    @(posedge core_clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
  endtask : addr_phase

  task automatic ahb_write(input logic [31:0] a, input logic [31:0] d);
    addr_phase(a, 1'b1);
    hwdata <= d;
    wait_rdy();
  endtask : ahb_write

  task automatic ahb_read(input logic [31:0] a, output logic [31:0] d);
    addr_phase(a, 1'b0);
    wait_rdy();
    d = hrdata;
  endtask : ahb_read

  ////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    logic [31:0] d;
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk("fault waking", 32'h0000_0000, 32'(fault_out_n));
    u_host.send_steps(1, 1'b1);
    chk("steps while waking", 32'h0000_0010, 32'(step_position));
    repeat (WAKE) @(posedge core_clk);
    chk("fault released", 32'h0000_0001, 32'(fault_out_n));
    chk("threshold a", 32'h0000_0019, 32'(chop_threshold[0]));
    ahb_read(OFS_CUR_REF, d);
    chk("cur ref reset", 32'h0000_8080, d);
    ahb_read(OFS_TIMING, d);
    chk("timing reset", 32'h0032_03E8, d);
    ahb_read(32'h0000_0020, d);
    chk("unmapped read", 32'h0000_0000, d);
    chk("okay response", 32'h0000_0000, 32'(hresp));
    ahb_write(OFS_CUR_REF, 32'h0000_0A64);
    repeat (3) @(posedge core_clk);
    chop_check: chk("threshold b", 32'h0000_0002, 32'(chop_threshold[1]));
    ahb_read(OFS_FULL_SCALE, d);
    chk("full scale", 32'h0000_0214, d);
    $display("test reset done");
  endtask : t_reset

  task automatic t_steps();
    logic [6:0] inc [4] = '{INC_FULL, INC_HALF, INC_QTR, INC_FINE};
    logic [6:0] exp_pos = HOME_POS;
    for (int c = 0; c < 4; c++)
    begin
      ahb_write(OFS_CTRL, 32'(c) << CTRL_SEL0);
      u_host.send_steps(4, 1'b1);
      exp_pos = exp_pos + 7'(4 * inc[c]);
      chk("position forward", 32'(exp_pos), 32'(step_position));
      u_host.send_steps(5, 1'b0);
      exp_pos = exp_pos - 7'(5 * inc[c]);
      chk("position reverse", 32'(exp_pos), 32'(step_position));
    end
    $display("test steps done");
  endtask : t_steps

  // Counts bridge A states over one whole PWM period of 300 cycles
  task automatic t_chop(input logic [1:0] code, input logic trip);
    int drv = 0;
    int fst = 0;
    int slw = 0;
    ahb_write(OFS_CTRL, 32'h0000_0001 | (32'(code) << CTRL_DEC_A) | (32'(code) << CTRL_DEC_B));
    sense[0].at_chop <= trip;
    repeat (700) @(posedge core_clk);
    repeat (300)
    begin
      @(posedge core_clk);
      if (bridge_out[0].mode === BR_DRIVE)
        drv++;
      if (bridge_out[0].mode === BR_FAST)
        fst++;
      if (bridge_out[0].mode === BR_SLOW)
        slw++;
    end
    if (!trip)
      chk("drive without trip", 32'd300, 32'(drv));
    else
    begin
      chk("blanked drive", 32'h0000_0001, 32'(drv >= 10 && drv <= 13));
      chk("decay fills period", 32'd300, 32'(drv + fst + slw));
      if (code == 2'(DEC_FAST))
        chk("fast only", 32'h0000_0000, 32'(slw));
      else if (code == 2'(DEC_MIXED))
        chk("mixed fast part", 32'h0000_0001, 32'(fst >= 99 && fst <= 102));
      else
        chk("slow only", 32'h0000_0000, 32'(fst));
    end
  endtask : t_chop

  task automatic t_phase();
    ahb_write(OFS_CTRL, 32'h0000_0005);
    bridge_drive_gate <= 2'b00;
    repeat (4) @(posedge core_clk);
    chk("gate low off", 32'(BR_OFF), 32'(bridge_out[0].mode));
    ahb_write(OFS_CTRL, 32'h0000_0001);
    repeat (4) @(posedge core_clk);
    chk("gate low slow", 32'(BR_SLOW), 32'(bridge_out[0].mode));
    bridge_drive_gate <= 2'b11;
    phase_in <= 2'b10;
    ahb_write(OFS_TIMING, 32'h000A_012C);
    // Polarity follows the phase inputs directly in this mode
    chk("phase polarity", 32'h0000_0002, 32'({bridge_out[1].fwd, bridge_out[0].fwd}));
    t_chop(2'h0, 1'b0);
    for (int c = 0; c < 4; c++)
      t_chop(2'(c), 1'b1);
    $display("test phase and chopping done");
  endtask : t_phase

  task automatic t_ovc();
    logic [31:0] d;
    sense <= '0;
    repeat (4) @(posedge core_clk);
    sense[0].over_trip <= 1'b1;
    @(posedge core_clk);
    sense[0].over_trip <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk("fault on trip", 32'h0000_0000, 32'(fault_out_n));
    chk("bridge a off", 32'(BR_OFF), 32'(bridge_out[0].mode));
    chk("bridge b runs", 32'(BR_DRIVE), 32'(bridge_out[1].mode));
    ahb_read(OFS_STATUS, d);
    chk("overcurrent flags", 32'h0000_0001, 32'(d[STAT_OVC+:2]));
    ahb_write(OFS_STATUS, 32'h0000_0100);
    repeat (3) @(posedge core_clk);
    chk("fault cleared", 32'h0000_0001, 32'(fault_out_n));
    // Trip held on bridge B while software clears it: the trip must win
    sense[1].over_trip <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk("bridge b off", 32'(BR_OFF), 32'(bridge_out[1].mode));
    ahb_write(OFS_STATUS, 32'h0000_0200);
    ahb_read(OFS_STATUS, d);
    chk("trip beats clear", 32'h0000_0002, 32'(d[STAT_OVC+:2]));
    sense[1].over_trip <= 1'b0;
    ahb_write(OFS_STATUS, 32'h0000_0200);
    repeat (3) @(posedge core_clk);
    chk("fault cleared b", 32'h0000_0001, 32'(fault_out_n));
    $display("test overcurrent done");
  endtask : t_ovc

  // Sleep must home the indexer and clear the registers, and steps in sleep are lost
  task automatic t_sleep();
    logic [31:0] d;
    ahb_write(OFS_CTRL, 32'h0000_0006);
    low_power_request_n <= 1'b0;
    u_host.send_steps(1, 1'b1);
    chk("sleep home", 32'h0000_0010, 32'(step_position));
    chk("sleep bridges", 32'h0000_0000, 32'(bridge_out));
    ahb_write(OFS_CTRL, 32'h0000_0001);
    low_power_request_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk("fault after wake", 32'h0000_0000, 32'(fault_out_n));
    repeat (WAKE + 2) @(posedge core_clk);
    chk("fault settles", 32'h0000_0001, 32'(fault_out_n));
    // Home position lies in the quadrant where both windings drive forward
    chk("home polarity", 32'h0000_0003, 32'({bridge_out[1].fwd, bridge_out[0].fwd}));
    ahb_read(OFS_CTRL, d);
    chk("ctrl after sleep", 32'h0000_0000, d);
    $display("test sleep done");
  endtask : t_sleep

  ////////////////////////////////////////
  // Main sequence and watchdog; the longest path is about 5500 cycles
  initial
  begin
    t_reset();
    t_steps();
    t_phase();
    t_ovc();
    t_sleep();
    close_out();
  end

  initial
  begin
    repeat (40000) @(posedge core_clk);
    num_errors++;
    $display("watchdog expired");
    close_out();
  end
endmodule : stp_core_tb
